/* rtl/sbf_exec_core.sv */
// Execution slice: stores, stack, I/O bit ops, shifts and flag ops behind AXI4-Lite
`timescale 1ns/10ps
`include "sbf_params.svh"
// Overview of operation
// - Post-increment store: write, bump pointer, 2 cycles
// - Pre-decrement store: drop pointer, then write, 2 cycles
// - Displacement store at pointer plus q, pointer kept
// - Direct store at instruction address, 2 cycles
// - Push register onto stack in 2 cycles
// - Pop stack into register in 2 cycles
// - Set one I/O register bit, 2 cycles
// - Clear one I/O register bit, 2 cycles
// - Rotate left through carry, flags, 1 cycle
// - Rotate right through carry, flags, 1 cycle
// - Arithmetic right shift keeps sign, 1 cycle
// - Copy register bit into transfer flag
// - Copy transfer flag into register bit
// - Global interrupt enable set, 1 cycle
// - Global interrupt enable cleared, 1 cycle
// - Signed test flag set, 1 cycle
// - Signed test flag cleared, 1 cycle
// - Overflow flag set, 1 cycle
// - Overflow flag cleared, 1 cycle
module sbf_exec_core #(
  parameter int AW = 8,
  parameter logic [15:0] STACK_RST = `SBF_STACK_RST
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  output logic dmem_re,
  input wire logic [7:0] dmem_rdata,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re,
  input wire logic [7:0] io_rdata,
  output logic busy,
  output logic global_irq_enable,
  output sbf_pkg::sbf_state_t exec_state
);
  import sbf_pkg::*;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic sbf_mapped(input logic [AW-1:0] a);
    sbf_mapped = (a[1:0] == 2'b00) && (a[`SBF_GPR_BIT] || (a <= AW'(`SBF_CYCLES)));
  endfunction : sbf_mapped

  function automatic logic sbf_two_cycle(input sbf_op_t o);
    sbf_two_cycle = (o >= op_memory_write_via_pointer) && (o <= op_io_bit_clear_op);
  endfunction : sbf_two_cycle

  sbf_state_t state;
  logic [7:0] flags;
  logic [7:0] gpr [32];
  logic [15:0] ptr [3];
  logic [15:0] sp;
  logic [31:0] cmd;
  logic [7:0] cycles;
  logic aw_held;
  logic w_held;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] wm;
  logic [31:0] src;
  logic wr_fire;
  logic wr_err;
  logic wr_en;
  logic cmd_go;
  logic [31:0] rd_word;
  sbf_op_t op;
  sbf_op_t src_op;
  logic [4:0] reg_idx;
  logic [4:0] src_reg;
  logic [1:0] psel;
  logic [1:0] src_psel;
  logic [15:0] cur_ptr;
  logic [15:0] src_ptr;
  logic [15:0] next_addr;
  logic [7:0] rd_val;
  logic [7:0] io_mask;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_wr;

  assign op = sbf_op_t'(cmd[`SBF_F_OP_HI:`SBF_F_OP_LO]);
  assign reg_idx = cmd[`SBF_F_REG_HI:`SBF_F_REG_LO];
  assign psel = cmd[`SBF_F_PSEL_HI:`SBF_F_PSEL_LO];
  assign src = w_data & wm;
  assign src_op = sbf_op_t'(src[`SBF_F_OP_HI:`SBF_F_OP_LO]);
  assign src_reg = src[`SBF_F_REG_HI:`SBF_F_REG_LO];
  assign src_psel = src[`SBF_F_PSEL_HI:`SBF_F_PSEL_LO];
  assign cur_ptr = (psel == 2'd0) ? ptr[0] : ((psel == 2'd1) ? ptr[1] : ptr[2]);
  assign src_ptr = (src_psel == 2'd0) ? ptr[0] : ((src_psel == 2'd1) ? ptr[1] : ptr[2]);
  assign rd_val = gpr[reg_idx];
  assign io_mask = 8'h01 << cmd[`SBF_F_BIT_HI:`SBF_F_BIT_LO];
  assign busy = (state != s_idle);
  assign exec_state = state;
  assign global_irq_enable = flags[`SBF_FLAG_I];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wm[8*g +: 8] = {8{w_strb[g]}};
    end
  endgenerate

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_err = busy || !sbf_mapped(aw_addr);
  assign wr_en = wr_fire && !wr_err;
  assign cmd_go = wr_en && (aw_addr == AW'(`SBF_CMD));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBF_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? `SBF_RESP_SLVERR : `SBF_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0;
    if (s_axi_araddr[`SBF_GPR_BIT]) begin
      rd_word = {24'h0, gpr[s_axi_araddr[6:2]]};
    end else begin
      case (s_axi_araddr)
        AW'(`SBF_CMD): rd_word = cmd;
        AW'(`SBF_STATUS): rd_word = {30'h0, flags[`SBF_FLAG_I], busy};
        AW'(`SBF_FLAGS): rd_word = {24'h0, flags};
        AW'(`SBF_PTR_X): rd_word = {16'h0, ptr[0]};
        AW'(`SBF_PTR_Y): rd_word = {16'h0, ptr[1]};
        AW'(`SBF_PTR_Z): rd_word = {16'h0, ptr[2]};
        AW'(`SBF_STACK): rd_word = {16'h0, sp};
        AW'(`SBF_CYCLES): rd_word = {24'h0, cycles};
        default: rd_word = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SBF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= sbf_mapped(s_axi_araddr) ? rd_word : 32'h0;
      s_axi_rresp <= sbf_mapped(s_axi_araddr) ? `SBF_RESP_OKAY : `SBF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Command latch, sequencer and cycle count
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cmd <= 32'h0;
    end else if (cmd_go) begin
      cmd <= src;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= s_idle;
    end else begin
      case (state)
        s_idle: if (cmd_go) state <= s_first;
        s_first: state <= sbf_two_cycle(op) ? s_second : s_idle;
        s_second: state <= s_idle;
        default: state <= s_idle;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cycles <= 8'h00;
    end else if (cmd_go) begin
      cycles <= 8'h00;
    end else if (busy) begin
      cycles <= cycles + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Memory and I/O requests
  // --------------------------------------------------------------------------
  always_comb begin
    case (src_op)
      op_memory_write_via_pointer_predec: next_addr = src_ptr - 16'h0001;
      op_displaced_pointer_write: next_addr = src_ptr + {10'h0, src[`SBF_F_Q_HI:`SBF_F_K_LO]};
      op_direct_data_write: next_addr = src[`SBF_F_K_HI:`SBF_F_K_LO];
      op_stack_push: next_addr = sp;
      op_stack_pop: next_addr = sp + 16'h0001;
      default: next_addr = src_ptr;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      dmem_addr <= 16'h0000;
      dmem_wdata <= 8'h00;
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      io_addr <= 6'h00;
      io_wdata <= 8'h00;
      io_we <= 1'b0;
      io_re <= 1'b0;
    end else if (cmd_go) begin
      dmem_addr <= next_addr;
      dmem_wdata <= gpr[src_reg];
      dmem_we <= (src_op >= op_memory_write_via_pointer) && (src_op <= op_stack_push);
      dmem_re <= (src_op == op_stack_pop);
      io_addr <= src[`SBF_F_K_LO+5:`SBF_F_K_LO];
      io_re <= (src_op == op_io_bit_set_op) || (src_op == op_io_bit_clear_op);
    end else if (state == s_first) begin
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      io_re <= 1'b0;
      io_we <= io_re;
      io_wdata <= (op == op_io_bit_set_op) ? (io_rdata | io_mask) : (io_rdata & ~io_mask);
    end else begin
      io_we <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Pointers and stack pointer
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        ptr[i] <= `SBF_PTR_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < 3; i++) begin
        if (aw_addr == AW'(`SBF_PTR_X + 4 * i)) ptr[i] <= (ptr[i] & ~wm[15:0]) | (w_data[15:0] & wm[15:0]);
      end
    end else if (state == s_first) begin
      if (op == op_memory_write_via_pointer_postinc) begin
        ptr[(psel > 2'd1) ? 2 : psel] <= dmem_addr + 16'h0001;
      end else if (op == op_memory_write_via_pointer_predec) begin
        ptr[(psel > 2'd1) ? 2 : psel] <= dmem_addr;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sp <= STACK_RST;
    end else if (wr_en && (aw_addr == AW'(`SBF_STACK))) begin
      sp <= (sp & ~wm[15:0]) | (w_data[15:0] & wm[15:0]);
    end else if (state == s_first) begin
      if (op == op_stack_push) sp <= sp - 16'h0001;
      else if (op == op_stack_pop) sp <= dmem_addr;
    end
  end

  // --------------------------------------------------------------------------
  // Register file and flags
  // --------------------------------------------------------------------------
  sbf_shift_unit u_shift (
    .op(op),
    .operand(rd_val),
    .flags_in(flags),
    .bit_sel(cmd[`SBF_F_BIT_HI:`SBF_F_BIT_LO]),
    .result(alu_res),
    .flags_out(alu_flags),
    .writes_reg(alu_wr)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= 8'h00;
      end
    end else if (wr_en && aw_addr[`SBF_GPR_BIT]) begin
      gpr[aw_addr[6:2]] <= (gpr[aw_addr[6:2]] & ~wm[7:0]) | (w_data[7:0] & wm[7:0]);
    end else if (state == s_first) begin
      if (op == op_stack_pop) gpr[reg_idx] <= dmem_rdata;
      else if (alu_wr) gpr[reg_idx] <= alu_res;
    end
  end

  // Memory ops pass flags through the unit unchanged
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flags <= `SBF_FLAGS_RST;
    end else if (wr_en && (aw_addr == AW'(`SBF_FLAGS))) begin
      flags <= (flags & ~wm[7:0]) | (w_data[7:0] & wm[7:0]);
    end else if (state == s_first) begin
      flags <= alu_flags;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  AST_POSTINC_WRITE: assert property (
    (state == s_first && op == op_memory_write_via_pointer_postinc)
      |-> (dmem_we && dmem_wdata == rd_val) ##1 (cur_ptr == $past(dmem_addr) + 16'h0001))
    else $error("post-increment store wrong");
  AST_PREDEC_WRITE: assert property (
    (state == s_first && op == op_memory_write_via_pointer_predec)
      |-> (dmem_we && dmem_addr == cur_ptr - 16'h0001) ##1 (cur_ptr == $past(dmem_addr)))
    else $error("pre-decrement store wrong");
  AST_DISP_WRITE: assert property (
    (state == s_first && op == op_displaced_pointer_write)
      |-> (dmem_we && dmem_addr == cur_ptr + {10'h0, cmd[`SBF_F_Q_HI:`SBF_F_K_LO]}) ##1 $stable(cur_ptr))
    else $error("displacement store wrong");
  AST_DIRECT_WRITE: assert property (
    (state == s_first && op == op_direct_data_write) |-> dmem_we && dmem_addr == cmd[`SBF_F_K_HI:`SBF_F_K_LO])
    else $error("direct store wrong");
  AST_MEM_TWO_CYCLES: assert property (
    (cmd_go && sbf_two_cycle(src_op)) |=> busy [*2] ##1 !busy)
    else $error("memory op not two cycles");
  AST_ALU_ONE_CYCLE: assert property (
    (cmd_go && !sbf_two_cycle(src_op)) |=> busy ##1 !busy)
    else $error("register op not one cycle");
  AST_MEM_FLAGS_KEPT: assert property (
    (state == s_first && sbf_two_cycle(op)) |=> $stable(flags) [*2])
    else $error("memory op changed flags");
  AST_IO_BIT_SET: assert property (
    (state == s_first && op == op_io_bit_set_op)
      |=> io_we && io_wdata == ($past(io_rdata) | $past(io_mask)))
    else $error("I/O bit set wrong");
  AST_ROTATE_LEFT: assert property (
    (state == s_first && op == op_rotate_left_carry)
      |=> flags[`SBF_FLAG_C] == $past(rd_val[7]) && rd_val[0] == $past(flags[`SBF_FLAG_C]))
    else $error("rotate left wrong");
  AST_IRQ_ON: assert property (
    (state == s_first && op == op_global_irq_on) |=> global_irq_enable && !busy)
    else $error("interrupt enable not set");

endmodule : sbf_exec_core

/* rtl/sbf_params.svh */
// Offsets, field positions, reset values and cycle counts of the execution slice
`ifndef SBF_PARAMS_SVH
`define SBF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SBF_CMD 8'h00
`define SBF_STATUS 8'h04
`define SBF_FLAGS 8'h08
`define SBF_PTR_X 8'h0c
`define SBF_PTR_Y 8'h10
`define SBF_PTR_Z 8'h14
`define SBF_STACK 8'h18
`define SBF_CYCLES 8'h1c
`define SBF_GPR_BIT 7

// ----------------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------------
`define SBF_F_OP_HI 4
`define SBF_F_OP_LO 0
`define SBF_F_REG_HI 9
`define SBF_F_REG_LO 5
`define SBF_F_BIT_HI 12
`define SBF_F_BIT_LO 10
`define SBF_F_PSEL_HI 14
`define SBF_F_PSEL_LO 13
`define SBF_F_K_HI 31
`define SBF_F_K_LO 16
`define SBF_F_Q_HI 21

// ----------------------------------------------------------------------------
// Flag positions in flags_register
// ----------------------------------------------------------------------------
`define SBF_FLAG_I 7
`define SBF_FLAG_T 6
`define SBF_FLAG_H 5
`define SBF_FLAG_S 4
`define SBF_FLAG_V 3
`define SBF_FLAG_N 2
`define SBF_FLAG_Z 1
`define SBF_FLAG_C 0

// ----------------------------------------------------------------------------
// Reset values, responses, cycle counts
// ----------------------------------------------------------------------------
`define SBF_FLAGS_RST 8'h00
`define SBF_PTR_RST 16'h0000
`define SBF_STACK_RST 16'h00ff
`define SBF_RESP_OKAY 2'b00
`define SBF_RESP_SLVERR 2'b10
`define SBF_CYC_MEM 2
`define SBF_CYC_ALU 1

`endif

/* rtl/sbf_pkg.sv */
// Types shared by the execution slice
package sbf_pkg;

  typedef enum logic [1:0] {
    s_idle = 2'b00,
    s_first = 2'b01,
    s_second = 2'b11
  } sbf_state_t;

  typedef enum logic [4:0] {
    op_none = 5'h00,
    op_memory_write_via_pointer = 5'h01,
    op_memory_write_via_pointer_postinc = 5'h02,
    op_memory_write_via_pointer_predec = 5'h03,
    op_displaced_pointer_write = 5'h04,
    op_direct_data_write = 5'h05,
    op_stack_push = 5'h06,
    op_stack_pop = 5'h07,
    op_io_bit_set_op = 5'h08,
    op_io_bit_clear_op = 5'h09,
    op_logical_left_shift = 5'h0a,
    op_logical_right_shift = 5'h0b,
    op_rotate_left_carry = 5'h0c,
    op_rotate_right_carry = 5'h0d,
    op_arithmetic_right_shift = 5'h0e,
    op_nibble_swap = 5'h0f,
    op_bit_to_transfer_flag = 5'h10,
    op_transfer_flag_to_bit = 5'h11,
    op_global_irq_on = 5'h12,
    op_global_irq_off = 5'h13,
    op_sign_flag_raise = 5'h14,
    op_sign_flag_lower = 5'h15,
    op_overflow_flag_raise = 5'h16,
    op_overflow_flag_lower = 5'h17,
    op_flag_bit_set = 5'h18,
    op_flag_bit_clear = 5'h19
  } sbf_op_t;

endpackage : sbf_pkg

/* rtl/sbf_shift_unit.sv */
// Single-cycle shift, bit transfer and flag unit
`timescale 1ns/10ps
`include "sbf_params.svh"
module sbf_shift_unit (
  input wire sbf_pkg::sbf_op_t op,
  input wire logic [7:0] operand,
  input wire logic [7:0] flags_in,
  input wire logic [2:0] bit_sel,
  output logic [7:0] result,
  output logic [7:0] flags_out,
  output logic writes_reg
);
  import sbf_pkg::*;

  logic carry_out;
  logic upd;

  always_comb begin
    result = operand;
    flags_out = flags_in;
    carry_out = 1'b0;
    upd = 1'b0;
    writes_reg = 1'b0;
    case (op)
      op_logical_left_shift: begin
        {carry_out, result} = {operand, 1'b0};
        upd = 1'b1;
      end
      op_logical_right_shift: begin
        {result, carry_out} = {1'b0, operand};
        upd = 1'b1;
      end
      op_rotate_left_carry: begin
        {carry_out, result} = {operand, flags_in[`SBF_FLAG_C]};
        upd = 1'b1;
      end
      op_rotate_right_carry: begin
        {result, carry_out} = {flags_in[`SBF_FLAG_C], operand};
        upd = 1'b1;
      end
      op_arithmetic_right_shift: begin
        {result, carry_out} = {operand[7], operand};
        upd = 1'b1;
      end
      op_nibble_swap: begin
        result = {operand[3:0], operand[7:4]};
        writes_reg = 1'b1;
      end
      op_bit_to_transfer_flag: begin
        flags_out[`SBF_FLAG_T] = operand[bit_sel];
      end
      op_transfer_flag_to_bit: begin
        result[bit_sel] = flags_in[`SBF_FLAG_T];
        writes_reg = 1'b1;
      end
      op_global_irq_on: flags_out[`SBF_FLAG_I] = 1'b1;
      op_global_irq_off: flags_out[`SBF_FLAG_I] = 1'b0;
      op_sign_flag_raise: flags_out[`SBF_FLAG_S] = 1'b1;
      op_sign_flag_lower: flags_out[`SBF_FLAG_S] = 1'b0;
      op_overflow_flag_raise: flags_out[`SBF_FLAG_V] = 1'b1;
      op_overflow_flag_lower: flags_out[`SBF_FLAG_V] = 1'b0;
      op_flag_bit_set: flags_out[bit_sel] = 1'b1;
      op_flag_bit_clear: flags_out[bit_sel] = 1'b0;
      default: upd = 1'b0;
    endcase
    if (upd) begin
      writes_reg = 1'b1;
      flags_out[`SBF_FLAG_Z] = (result == 8'h00);
      flags_out[`SBF_FLAG_C] = carry_out;
      flags_out[`SBF_FLAG_N] = result[7];
      flags_out[`SBF_FLAG_V] = result[7] ^ carry_out;
    end
  end

endmodule : sbf_shift_unit

/* tb/sbf_mem_model.sv */
// Data memory and I/O register model facing the execution slice
`timescale 1ns/10ps
module sbf_mem_model (
  input wire logic clock,
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic dmem_re,
  output logic [7:0] dmem_rdata,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] io [0:63];
  // ---------------------------------------------------------------
  // Asynchronous reads, inverted when not strobed
  // ---------------------------------------------------------------
  assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~mem[dmem_addr];
  assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
  always @(posedge clock) begin
    if (dmem_we) mem[dmem_addr] <= dmem_wdata;
    if (io_we) io[io_addr] <= io_wdata;
  end
endmodule : sbf_mem_model

/* tb/tb_store_bitop_flag_exec.sv */
// Self-checking bench for the execution slice
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_store_bitop_flag_exec;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awa = '0, ara = '0, v, f, p, fe, dm_wd, dm_rd, io_wd, io_rd;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [31:0] wd = '0, rdt, d;
  logic awr, wr_rdy, bv, arr, rv, busy, gie, dm_we, dm_re, io_we, io_re;
  logic [1:0] bresp, rresp, resp, st;
  logic [15:0] dm_a, a, e, pe, x;
  logic [5:0] io_a, q;
  logic [4:0] op;
  logic [2:0] b;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  always #10 clock = ~clock;
  sbf_exec_core dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .dmem_addr(dm_a), .dmem_wdata(dm_wd), .dmem_we(dm_we), .dmem_re(dm_re), .dmem_rdata(dm_rd),
    .io_addr(io_a), .io_wdata(io_wd), .io_we(io_we), .io_re(io_re), .io_rdata(io_rd), .busy(busy),
    .global_irq_enable(gie), .exec_state(st));
  sbf_mem_model mem_i (.clock(clock), .dmem_addr(dm_a), .dmem_wdata(dm_wd), .dmem_we(dm_we),
    .dmem_re(dm_re), .dmem_rdata(dm_rd), .io_addr(io_a), .io_wdata(io_wd), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rd));
  // ---------------------------------------------------------------
  // Bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    awa <= ad;
    wd <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clock);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) br <= 1'b0;
      resp = bresp;
    end while (!bv);
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    ara <= ad;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clock);
      if (arr) arv <= 1'b0;
      if (rv) rr <= 1'b0;
      dt = rdt;
      resp = rresp;
    end while (!rv);
    @(posedge clock);
  endtask : rd
  task automatic run(input logic [4:0] o, input logic [4:0] r, input logic [2:0] bt, input logic [1:0] ps,
                     input logic [15:0] k, input logic [31:0] cy);
    wr(8'h00, {k, 1'b0, ps, bt, r, o});
    `CHK("cmd resp", 2'b00, resp)
    `CHK("exec state", (cy == 2) ? 2'b11 : 2'b00, st)
    while (busy) @(posedge clock);
    rd(8'h1c, d);
    `CHK("cycles", cy, d)
  endtask : run
  task automatic chkf(input logic [7:0] ef);
    rd(8'h08, d);
    `CHK("flags", ef, d[7:0])
  endtask : chkf
  function automatic logic [15:0] exp_alu(input logic [4:0] o, input logic [7:0] s, input logic [7:0] fl);
    logic [7:0] r;
    logic c;
    c = s[0];
    case (o)
      5'h0a: begin r = {s[6:0], 1'b0}; c = s[7]; end
      5'h0b: r = {1'b0, s[7:1]};
      5'h0c: begin r = {s[6:0], fl[0]}; c = s[7]; end
      5'h0d: r = {fl[0], s[7:1]};
      5'h0e: r = {s[7], s[7:1]};
      default: return {fl, s[3:0], s[7:4]};
    endcase
    return {fl[7:4], r[7] ^ c, r[7], r == 8'h00, c, r};
  endfunction : exp_alu
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(80726));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chkf(8'h00);
    rd(8'h18, d);
    `CHK("stack rst", 32'h0000_00ff, d)
    rd(8'h40, d);
    `CHK("unmapped rd", 2'b10, resp)
    `CHK("unmapped data", 32'h0, d)
    wr(8'h40, 32'h0);
    `CHK("unmapped wr", 2'b10, resp)
    f = 8'($urandom);
    wr(8'h08, {24'h0, f});
    for (int m = 0; m < 4; m++) begin
      a = 16'h0100 + 16'($urandom_range(0, 255));
      q = 6'($urandom);
      v = 8'($urandom);
      p = (m == 3) ? 8'h14 : 8'h0c + 8'(4 * m);
      wr(p, {16'h0, a});
      wr(8'h84, {24'h0, v});
      run((m == 3) ? 5'h01 : 5'(m + 2), 5'd1, 3'd0, 2'(m), {10'h0, q}, 2);
      e = (m == 1) ? a - 16'h1 : (m == 2) ? a + 16'(q) : a;
      pe = (m == 0) ? a + 16'h1 : (m == 1) ? a - 16'h1 : a;
      `CHK("stored", v, mem_i.mem[e])
      rd(p, d);
      `CHK("pointer", {16'h0, pe}, d)
      chkf(f);
    end
    a = 16'($urandom);
    run(5'h05, 5'd1, 3'd0, 2'd0, a, 2);
    `CHK("direct", v, mem_i.mem[a])
    run(5'h06, 5'd1, 3'd0, 2'd0, 16'h0, 2);
    `CHK("pushed", v, mem_i.mem[16'h00ff])
    run(5'h07, 5'd5, 3'd0, 2'd0, 16'h0, 2);
    rd(8'h94, d);
    `CHK("popped", v, d[7:0])
    rd(8'h18, d);
    `CHK("stack", 32'h0000_00ff, d)
    chkf(f);
    for (int s = 0; s < 4; s++) begin
      p = 8'($urandom_range(0, 63));
      v = 8'($urandom);
      b = 3'($urandom);
      mem_i.io[p[5:0]] = v;
      run(5'h08 + 5'(s % 2), 5'd0, b, 2'd0, {10'h0, p[5:0]}, 2);
      fe = s[0] ? v & ~(8'h01 << b) : v | (8'h01 << b);
      `CHK("io reg", fe, mem_i.io[p[5:0]])
      chkf(f);
    end
    for (int i = 0; i < 18; i++) begin
      op = 5'h0a + 5'(i % 6);
      v = (i < 6) ? 8'h00 : 8'($urandom);
      f = 8'($urandom);
      wr(8'h08, {24'h0, f});
      wr(8'h88, {24'h0, v});
      run(op, 5'd2, 3'd0, 2'd0, 16'h0, 1);
      x = exp_alu(op, v, f);
      rd(8'h88, d);
      `CHK("shifted", x[7:0], d[7:0])
      chkf(x[15:8]);
    end
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      b = 3'($urandom);
      p = 8'($urandom);
      wr(8'h8c, {24'h0, v});
      wr(8'h90, {24'h0, p});
      run(5'h10, 5'd3, b, 2'd0, 16'h0, 1);
      f[6] = v[b];
      chkf(f);
      b = 3'($urandom);
      run(5'h11, 5'd4, b, 2'd0, 16'h0, 1);
      p[b] = f[6];
      rd(8'h90, d);
      `CHK("bit load", p, d[7:0])
      chkf(f);
    end
    for (int i = 0; i < 12; i++) begin
      f = 8'($urandom);
      wr(8'h08, {24'h0, f});
      run(5'h12 + 5'(i % 6), 5'd0, 3'd0, 2'd0, 16'h0, 1);
      fe = f;
      fe[(i % 6) < 2 ? 7 : ((i % 6) < 4 ? 4 : 3)] = ~i[0];
      chkf(fe);
      `CHK("irq enable", fe[7], gie)
      rd(8'h04, d);
      `CHK("status", {30'h0, fe[7], 1'b0}, d)
    end
    b = 3'($urandom);
    f = fe;
    run(5'h18, 5'd0, b, 2'd0, 16'h0, 1);
    f[b] = 1'b1;
    chkf(f);
    run(5'h19, 5'd0, b, 2'd0, 16'h0, 1);
    f[b] = 1'b0;
    chkf(f);
    test_done();
  end
endmodule : tb_store_bitop_flag_exec
